//--- hdl/fcr_cmd_check.sv
// Command decode: code validity, availability per mode and security, expected object index.
`timescale 1ns/1ps
module fcr_cmd_check (
  // Command under test
  input  wire logic [7:0] cmd,
  input  wire logic [2:0] idx,
  // Chip state
  input  wire logic       special,
  input  wire logic       secured,
  // Verdict
  output logic            cmd_ok
);

  logic known;
  logic allowed;
  logic idx_ok;

  always_comb begin
    known = (cmd >= fcr_pkg::CMD_VFY_ALL) && (cmd <= fcr_pkg::CMD_LAST) &&
            (cmd != fcr_pkg::CMD_HOLE) && (cmd != 8'h0F);
    allowed = known;
    if (special && secured) begin
      allowed = (cmd == fcr_pkg::CMD_VFY_ALL) || (cmd == fcr_pkg::CMD_VFY_BLK) ||
                (cmd == fcr_pkg::CMD_ERS_ALL) || (cmd == fcr_pkg::CMD_UNSECURE);
    end else if (!special) begin
      if ((cmd == fcr_pkg::CMD_ERS_ALL) || (cmd == fcr_pkg::CMD_UNSECURE) ||
          (cmd == fcr_pkg::CMD_FLD_MRG)) begin
        allowed = 1'b0;
      end
    end else if (cmd == fcr_pkg::CMD_BACKDOOR) begin
      allowed = 1'b0;
    end
    unique case (cmd)
      fcr_pkg::CMD_ERS_ALL: idx_ok = (idx == fcr_pkg::IX_ERS_ALL);
      fcr_pkg::CMD_PG_ONCE: idx_ok = (idx == fcr_pkg::IX_PG_ONCE);
      fcr_pkg::CMD_VFY_ALL: idx_ok = (idx == fcr_pkg::IX_ERS_ALL);
      fcr_pkg::CMD_VFY_SEC: idx_ok = (idx == fcr_pkg::IX_VFY_SEC);
      default:              idx_ok = 1'b1;
    endcase
    cmd_ok = allowed && idx_ok;
  end

endmodule

//--- hdl/fcr_pkg.sv
// Package with the register map, field layout, command codes and carriers of the flash sequencer.
package fcr_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [4:0] IDX_RSV0    = 5'h03;
  localparam logic [4:0] IDX_CFG     = 5'h04;
  localparam logic [4:0] IDX_FCFG    = 5'h05;
  localparam logic [4:0] IDX_STAT    = 5'h06;
  localparam logic [4:0] IDX_COMMAND_STATUS   = 5'h07;
  localparam logic [4:0] IDX_PPROT   = 5'h08;
  localparam logic [4:0] IDX_DPROT   = 5'h09;
  localparam logic [4:0] IDX_COBHI   = 5'h0A;
  localparam logic [4:0] IDX_COBLO   = 5'h0B;
  localparam logic [4:0] IDX_RSV1    = 5'h0C;
  localparam logic [4:0] IDX_RSV4    = 5'h0F;
  localparam logic [4:0] IDX_OPT     = 5'h10;
  localparam logic [4:0] IDX_COBIX   = 5'h02;

  // Field positions.
  localparam int CFG_COMPLETE_IRQ_ENABLE   = 7;
  localparam int CFG_IGNORE_SINGLE_FAULT  = 4;
  localparam int CFG_FORCE_DOUBLE_FAULT   = 1;
  localparam int CFG_FORCE_SINGLE_FAULT   = 0;
  localparam int ST_COMMAND_COMPLETE_FLAG    = 7;
  localparam int ST_ACCESS_ERROR_FLAG  = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG  = 4;
  localparam int ST_BUSY    = 3;
  localparam int ST_MG1     = 1;
  localparam int ST_MG0     = 0;
  localparam int FL_DOUBLE  = 1;
  localparam int FL_SINGLE  = 0;
  localparam int PP_OPEN    = 7;
  localparam int PP_HDIS    = 5;
  localparam int DP_OPEN    = 7;

  // Writable masks and values after reset.
  localparam logic [7:0] CFG_MASK    = 8'h93;
  localparam logic [7:0] DPROT_MASK  = 8'h9F;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [1:0] FCFG_RST    = 2'h0;
  localparam logic [7:0] PPROT_RST   = 8'hFF;
  localparam logic [7:0] DPROT_RST   = 8'h9F;
  localparam logic [7:0] INIT_CYCLES = 8'h10;

  // Command codes.
  localparam logic [7:0] CMD_VFY_ALL  = 8'h01;
  localparam logic [7:0] CMD_VFY_BLK  = 8'h02;
  localparam logic [7:0] CMD_VFY_SEC  = 8'h03;
  localparam logic [7:0] CMD_RD_ONCE  = 8'h04;
  localparam logic [7:0] CMD_HOLE     = 8'h05;
  localparam logic [7:0] CMD_PG_ONCE  = 8'h07;
  localparam logic [7:0] CMD_ERS_ALL  = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK  = 8'h09;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
  localparam logic [7:0] CMD_FLD_MRG  = 8'h0E;
  localparam logic [7:0] CMD_LAST     = 8'h12;
  localparam logic [2:0] IX_ERS_ALL   = 3'h0;
  localparam logic [2:0] IX_PG_ONCE   = 3'h5;
  localparam logic [2:0] IX_VFY_SEC   = 3'h2;
  localparam logic [2:0] IX_LAST      = 3'h5;
  localparam logic [15:0] ONCE_PHRASES = 16'h0008;

  // Global address windows.
  localparam logic [17:0] PFL_LO = 18'h3_C000;
  localparam logic [17:0] PFL_HI = 18'h3_FFFF;
  localparam logic [17:0] RES_LO = 18'h0_4000;
  localparam logic [17:0] RES_HI = 18'h0_7FFF;
  localparam logic [17:0] EE_LO  = 18'h0_0400;
  localparam logic [17:0] EE_HI  = 18'h0_05FF;

  typedef enum logic [1:0] {S_INIT, S_IDLE, S_EXEC, S_VERIFY} fcr_seq_e;

  // Request to the array engine.
  typedef struct packed {
    logic        start;
    logic        verify;
    logic [7:0]  cmd;
    logic [15:0] param;
  } fcr_arr_req_s;

  // Answer from the array engine; done is a one-cycle pulse.
  typedef struct packed {
    logic done;
    logic err_any;
    logic err_uncorr;
    logic refused;
  } fcr_arr_rsp_s;

  // One CPU read of the array with its error-correction result.
  typedef struct packed {
    logic rd;
    logic single;
    logic double;
  } fcr_ecc_ev_s;

  // Which window a global address falls in.
  typedef struct packed {
    logic pflash;
    logic resource;
    logic eeprom;
  } fcr_region_s;

endpackage

//--- hdl/fcr_top.sv
// Register interface and command sequencer of the flash controller, with an APB slave.
`timescale 1ns/1ps
module fcr_top (
  // Clock, reset and enable
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Chip mode controller
  input  wire logic                 special_mode_input,
  input  wire logic                 secure_input,
  input  wire logic [7:0]           nv_options,
  // Array engine
  output fcr_pkg::fcr_arr_req_s     arr_req,
  input  wire fcr_pkg::fcr_arr_rsp_s arr_rsp,
  input  wire fcr_pkg::fcr_ecc_ev_s ecc_ev,
  // Address map
  input  wire logic [17:0]          glb_addr,
  input  wire logic                 resource_area_select,
  output fcr_pkg::fcr_region_s      region,
  // Status to the system
  output logic                      security_released,
  output logic                      complete_irq,
  output logic                      fault_irq
);

  typedef struct packed {
    fcr_pkg::fcr_seq_e     st;
    logic [7:0]            init_cnt;
    logic [7:0]            cfg;
    logic [1:0]            fcfg;
    logic                  command_complete_flag;
    logic                  access_error_flag;
    logic                  protection_violation_flag;
    logic                  mg1;
    logic                  mg0;
    logic [1:0]            flt;
    logic [7:0]            pprot;
    logic [7:0]            dprot;
    logic [7:0]            opt;
    logic [2:0]            idx;
    logic [5:0][15:0]      cob;
    logic                  released;
    fcr_pkg::fcr_arr_req_s req;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  cc_irq;
    logic                  f_irq;
    fcr_pkg::fcr_region_s  region;
  } fcr_state_s;

  fcr_state_s s_q;
  fcr_state_s s_d;

  logic       cmd_ok;
  logic       secured;
  logic [4:0] ridx;
  logic       wr;
  logic       rd_setup;
  logic       busy;
  logic [7:0] cmd_code;

  // Maps a bus address onto a register index; unmapped words give zero.
  function automatic logic [4:0] fcr_decode(input logic [31:0] a);
    logic [4:0] i;
    i = a[6:2];
    if ((a[31:7] != 25'h000_0000) || (i < fcr_pkg::IDX_COBIX) || (i > fcr_pkg::IDX_OPT)) begin
      i = 5'h00;
    end
    return i;
  endfunction

  // True when an address falls in the closed window lo to hi.
  function automatic logic fcr_in(input logic [17:0] a, input logic [17:0] lo,
                                  input logic [17:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // One byte of the selected object word; indices without storage read as zero.
  function automatic logic [7:0] fcr_obj_byte(input logic [5:0][15:0] cob,
                                               input logic [2:0]       ix,
                                               input logic             hi);
    logic [15:0] w;
    w = 16'h0000;
    if (ix <= fcr_pkg::IX_LAST) begin
      w = cob[ix];
    end
    return hi ? w[15:8] : w[7:0];
  endfunction

  // Builds the status byte; unused bit positions read zero.
  function automatic logic [7:0] fcr_status_byte(input fcr_state_s s, input logic bsy);
    logic [7:0] b;
    b = 8'h00;
    b[fcr_pkg::ST_COMMAND_COMPLETE_FLAG]   = s.command_complete_flag;
    b[fcr_pkg::ST_ACCESS_ERROR_FLAG] = s.access_error_flag;
    b[fcr_pkg::ST_PROTECTION_VIOLATION_FLAG] = s.protection_violation_flag;
    b[fcr_pkg::ST_BUSY]   = bsy;
    b[fcr_pkg::ST_MG1]    = s.mg1;
    b[fcr_pkg::ST_MG0]    = s.mg0;
    return b;
  endfunction

  assign secured  = secure_input && !s_q.released;
  assign ridx     = fcr_decode(paddr);
  assign rd_setup = psel && !penable && !s_q.pready;
  assign wr       = psel && penable && pwrite && s_q.pready && pstrb[0] && !s_q.pslverr;
  assign busy     = (s_q.st == fcr_pkg::S_EXEC) || (s_q.st == fcr_pkg::S_VERIFY);
  assign cmd_code = s_q.cob[0][15:8];

  fcr_cmd_check u_check (
    .cmd     (cmd_code),
    .idx     (s_q.idx),
    .special (special_mode_input),
    .secured (secured),
    .cmd_ok  (cmd_ok)
  );

  always_comb begin
    logic       wr_ok;
    logic       launch;
    logic [7:0] wd;
    logic [7:0] rv;
    logic       any_prot;
    wr_ok    = 1'b0;
    launch   = 1'b0;
    wd       = pwdata[7:0];
    rv       = 8'h00;
    any_prot = 1'b0;
    s_d      = s_q;
    s_d.req.start = 1'b0;

    // The APB answer has no wait state: data is staged in the setup cycle.
    s_d.pready = rd_setup;
    if (rd_setup) begin
      // Unmapped words answer with an error response and read as zero.
      s_d.pslverr = (ridx == 5'h00);
      unique case (ridx)
        fcr_pkg::IDX_COBIX: rv = {5'h00, s_q.idx};
        fcr_pkg::IDX_CFG:   rv = s_q.cfg & fcr_pkg::CFG_MASK;
        fcr_pkg::IDX_FCFG:  rv = {6'h00, s_q.fcfg};
        fcr_pkg::IDX_STAT:  rv = fcr_status_byte(s_q, busy);
        fcr_pkg::IDX_COMMAND_STATUS: rv = {6'h00, s_q.flt};
        fcr_pkg::IDX_PPROT: rv = s_q.pprot;
        fcr_pkg::IDX_DPROT: rv = s_q.dprot & fcr_pkg::DPROT_MASK;
        fcr_pkg::IDX_COBHI: rv = fcr_obj_byte(s_q.cob, s_q.idx, 1'b1);
        fcr_pkg::IDX_COBLO: rv = fcr_obj_byte(s_q.cob, s_q.idx, 1'b0);
        fcr_pkg::IDX_OPT:   rv = s_q.opt;
        default:            rv = 8'h00;
      endcase
      s_d.prdata = {24'h00_0000, rv};
    end else begin
      s_d.pslverr = 1'b0;
    end

    // Writes land only when idle or still initializing.
    wr_ok = wr && (s_q.command_complete_flag || (s_q.st == fcr_pkg::S_INIT));
    if (wr_ok) begin
      unique case (ridx)
        fcr_pkg::IDX_COBIX: s_d.idx = wd[2:0];
        fcr_pkg::IDX_CFG:   s_d.cfg = wd & fcr_pkg::CFG_MASK;
        fcr_pkg::IDX_FCFG:  s_d.fcfg = wd[1:0];
        fcr_pkg::IDX_STAT: begin
          if (wd[fcr_pkg::ST_ACCESS_ERROR_FLAG]) begin
            s_d.access_error_flag = 1'b0;
          end
          if (wd[fcr_pkg::ST_PROTECTION_VIOLATION_FLAG]) begin
            s_d.protection_violation_flag = 1'b0;
          end
          // A launch in this write still sees the old error flags and is refused.
          launch = wd[fcr_pkg::ST_COMMAND_COMPLETE_FLAG] && s_q.command_complete_flag && (s_q.st == fcr_pkg::S_IDLE);
        end
        fcr_pkg::IDX_COMMAND_STATUS: s_d.flt = s_q.flt & ~wd[1:0];
        fcr_pkg::IDX_PPROT: s_d.pprot = wd;
        fcr_pkg::IDX_DPROT: s_d.dprot = wd & fcr_pkg::DPROT_MASK;
        // Object words six and seven have no storage, so writes to them are dropped.
        fcr_pkg::IDX_COBHI: begin
          if (s_q.idx <= fcr_pkg::IX_LAST) begin
            s_d.cob[s_q.idx][15:8] = wd;
          end
        end
        fcr_pkg::IDX_COBLO: begin
          if (s_q.idx <= fcr_pkg::IX_LAST) begin
            s_d.cob[s_q.idx][7:0] = wd;
          end
        end
        default: s_d.idx = s_q.idx;
      endcase
    end

    // Array read faults: forced bits always flag, real single faults may be hidden.
    // A fault in the same cycle as a clear wins, so no event is lost.
    if (ecc_ev.rd) begin
      if (ecc_ev.double || s_q.cfg[fcr_pkg::CFG_FORCE_DOUBLE_FAULT]) begin
        s_d.flt[fcr_pkg::FL_DOUBLE] = 1'b1;
      end
      if ((ecc_ev.single && !s_q.cfg[fcr_pkg::CFG_IGNORE_SINGLE_FAULT]) || s_q.cfg[fcr_pkg::CFG_FORCE_SINGLE_FAULT]) begin
        s_d.flt[fcr_pkg::FL_SINGLE] = 1'b1;
      end
    end

    // Any closed protection region stops erase-all before the engine is asked.
    any_prot = !s_q.pprot[fcr_pkg::PP_OPEN] || !s_q.pprot[fcr_pkg::PP_HDIS] ||
               !s_q.dprot[fcr_pkg::DP_OPEN];

    unique case (s_q.st)
      fcr_pkg::S_INIT: begin
        // Options are copied on every init cycle, so a late settling value still lands.
        s_d.opt      = nv_options;
        s_d.init_cnt = s_q.init_cnt + 8'h01;
        if (s_q.init_cnt == fcr_pkg::INIT_CYCLES) begin
          s_d.st   = fcr_pkg::S_IDLE;
          s_d.command_complete_flag = 1'b1;
        end
      end
      fcr_pkg::S_IDLE: begin
        if (launch && !s_q.access_error_flag && !s_q.protection_violation_flag) begin
          if (!cmd_ok) begin
            s_d.access_error_flag = 1'b1;
          end else if ((cmd_code == fcr_pkg::CMD_PG_ONCE) &&
                       (s_q.cob[1] >= fcr_pkg::ONCE_PHRASES)) begin
            s_d.access_error_flag = 1'b1;
          end else if ((cmd_code == fcr_pkg::CMD_ERS_ALL) && any_prot) begin
            s_d.protection_violation_flag = 1'b1;
          end else begin
            // Verify-all, erase-block and the rest are carried out by the engine.
            s_d.command_complete_flag       = 1'b0;
            s_d.mg1        = 1'b0;
            s_d.mg0        = 1'b0;
            s_d.st         = fcr_pkg::S_EXEC;
            s_d.req.start  = 1'b1;
            s_d.req.verify = 1'b0;
            s_d.req.cmd    = cmd_code;
            s_d.req.param  = s_q.cob[1];
          end
        end
      end
      fcr_pkg::S_EXEC: begin
        if (arr_rsp.done) begin
          // A refusal from the engine ends the command at once with an access error.
          if (arr_rsp.refused) begin
            s_d.access_error_flag = 1'b1;
            s_d.command_complete_flag   = 1'b1;
            s_d.st     = fcr_pkg::S_IDLE;
          end else if (s_q.req.cmd == fcr_pkg::CMD_ERS_ALL) begin
            s_d.st         = fcr_pkg::S_VERIFY;
            s_d.req.start  = 1'b1;
            s_d.req.verify = 1'b1;
          end else begin
            s_d.mg1  = arr_rsp.err_any;
            s_d.mg0  = arr_rsp.err_uncorr;
            s_d.command_complete_flag = 1'b1;
            s_d.st   = fcr_pkg::S_IDLE;
          end
        end
      end
      fcr_pkg::S_VERIFY: begin
        if (arr_rsp.done) begin
          s_d.mg1  = arr_rsp.err_any;
          s_d.mg0  = arr_rsp.err_uncorr;
          s_d.command_complete_flag = 1'b1;
          s_d.st   = fcr_pkg::S_IDLE;
          // Security stays released until reset; only a clean verify pass frees it.
          if (!arr_rsp.err_any) begin
            s_d.released = 1'b1;
          end
        end
      end
    endcase

    s_d.cc_irq = s_d.command_complete_flag && s_d.cfg[fcr_pkg::CFG_COMPLETE_IRQ_ENABLE];
    s_d.f_irq  = |(s_d.flt & s_d.fcfg);

    // The decode is registered, so region follows glb_addr by one cycle.
    s_d.region.pflash   = fcr_in(glb_addr, fcr_pkg::PFL_LO, fcr_pkg::PFL_HI);
    s_d.region.resource = resource_area_select &&
                          fcr_in(glb_addr, fcr_pkg::RES_LO, fcr_pkg::RES_HI);
    s_d.region.eeprom   = fcr_in(glb_addr, fcr_pkg::EE_LO, fcr_pkg::EE_HI);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // The state and the registers with a reset constant are named below; cfg and fcfg reset to zero.
      s_q          <= '0;
      s_q.st       <= fcr_pkg::S_INIT;
      s_q.cfg      <= fcr_pkg::CFG_RST;
      s_q.fcfg     <= fcr_pkg::FCFG_RST;
      s_q.pprot    <= fcr_pkg::PPROT_RST;
      s_q.dprot    <= fcr_pkg::DPROT_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register, so none of them can glitch.
  assign prdata            = s_q.prdata;
  assign pready            = s_q.pready;
  assign pslverr           = s_q.pslverr;
  assign arr_req           = s_q.req;
  assign region            = s_q.region;
  assign security_released = s_q.released;
  assign complete_irq      = s_q.cc_irq;
  assign fault_irq         = s_q.f_irq;

endmodule

//--- testbench/fcr_properties.sv
// Port-level properties of the flash sequencer.
`timescale 1ns/1ps
module fcr_properties (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  // Register bus
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Decode, engine and status
  input wire logic [17:0]           glb_addr,
  input wire logic                  resource_area_select,
  input wire fcr_pkg::fcr_region_s  region,
  input wire fcr_pkg::fcr_arr_req_s arr_req,
  input wire logic                  security_released
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_answer_once: assert property (ce && psel && !penable |=> pready ##1 !pready)
    else $error("bus answer is not one cycle after setup");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr[31:7] != 25'h0
    || paddr[6:2] < 5'h02 || paddr[6:2] > 5'h10))
    else $error("error response does not match the address map");
  a_byte_read: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_pflash_map: assert property (ce |=> region.pflash ==
    ($past(glb_addr) inside {[fcr_pkg::PFL_LO:fcr_pkg::PFL_HI]}))
    else $error("program array decode wrong");
  a_resource_map: assert property (ce |=> region.resource == ($past(resource_area_select)
    && $past(glb_addr) inside {[fcr_pkg::RES_LO:fcr_pkg::RES_HI]}))
    else $error("resource area decode wrong");
  a_start_pulse: assert property (arr_req.start |=> !arr_req.start)
    else $error("start longer than one cycle");
  a_cmd_hold: assert property (!$stable(arr_req.cmd) |-> arr_req.start)
    else $error("command changed without a launch");
  a_release_sticky: assert property (security_released |=> security_released)
    else $error("security release dropped");

  c_erase_all: cover property (arr_req.start && arr_req.cmd == fcr_pkg::CMD_ERS_ALL);
  c_release: cover property ($rose(security_released));
  c_slverr: cover property (pslverr);
  c_resource: cover property (region.resource);
endmodule

//--- testbench/fcr_top_tb.sv
// Self-checking bench of the flash sequencer driven over its register bus.
`timescale 1ns/1ps
module fcr_top_tb;
  logic                  mclk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [31:0]           paddr, pwdata, prdata;
  logic [3:0]            pstrb;
  logic                  sp, sec, rsel, rel, cirq, firq, err, e, eany, eunc;
  logic [7:0]            nvo, rd;
  logic [17:0]           gaddr;
  fcr_pkg::fcr_arr_req_s req;
  fcr_pkg::fcr_arr_rsp_s rsp;
  fcr_pkg::fcr_ecc_ev_s  ecc;
  fcr_pkg::fcr_region_s  reg_o;
  int                    bad_count, check_count, starts, s0, cnt, dly;
  logic [7:0]  codes[11] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0C,
                             8'h0E, 8'h13, 8'h08};
  logic [17:0] ga[6] = '{18'h3_C000, 18'h3_FFFF, 18'h3_BFFF, 18'h0_4000, 18'h0_7FFF,
                         18'h0_0400};
  logic [3:0]  gx[6] = '{4'h4, 4'h4, 4'h0, 4'hA, 4'h0, 4'h1};
  logic [4:0]  rsv[4] = '{fcr_pkg::IDX_RSV0, fcr_pkg::IDX_RSV1, fcr_pkg::IDX_RSV4,
                          fcr_pkg::IDX_OPT};

  fcr_top fcr_top_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode_input(sp), .secure_input(sec),
    .nv_options(nvo), .arr_req(req), .arr_rsp(rsp), .ecc_ev(ecc), .glb_addr(gaddr),
    .resource_area_select(rsel), .region(reg_o), .security_released(rel),
    .complete_irq(cirq), .fault_irq(firq));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Stand-in for the array engine: every start is answered dly cycles later.
  always @(posedge mclk) begin
    rsp <= {cnt == 1, eany, eunc, 1'b0};
    if (req.start === 1'b1) begin
      starts <= starts + 1;
      cnt <= dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; the request stands until pready is seen at an edge.
  task automatic xfer(input logic w, input logic [4:0] ix, input logic [7:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {25'h000_0000, ix, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      end_sim();
    end
  endtask

  task automatic rchk(input logic [4:0] ix, input logic [7:0] exp);
    xfer(1'b0, ix, 8'h00);
    chk({24'h00_0000, rd}, {24'h00_0000, exp});
  endtask

  task automatic go(input logic [7:0] c, input logic [2:0] ix, input logic [7:0] w1);
    xfer(1'b1, fcr_pkg::IDX_COBIX, 8'h01);
    xfer(1'b1, fcr_pkg::IDX_COBLO, w1);
    xfer(1'b1, fcr_pkg::IDX_COBHI, 8'h00);
    xfer(1'b1, fcr_pkg::IDX_COBIX, 8'h00);
    xfer(1'b1, fcr_pkg::IDX_COBHI, c);
    xfer(1'b1, fcr_pkg::IDX_COBIX, {5'h00, ix});
    xfer(1'b1, fcr_pkg::IDX_STAT, 8'h80);
  endtask

  // Polls status until completion; leaves the last status byte in rd.
  task automatic idle;
    int n = 0;
    do begin
      xfer(1'b0, fcr_pkg::IDX_STAT, 8'h00);
      n++;
    end while (rd[7] !== 1'b1 && n < 100);
    if (n >= 100) begin
      bad_count++;
      end_sim();
    end
  endtask

  task automatic launch(input logic [7:0] c, input logic [2:0] ix, input logic [7:0] w1);
    go(c, ix, w1);
    idle();
  endtask

  task automatic ecc_rd(input logic [2:0] ev, input logic [7:0] exp);
    ecc <= ev;
    @(posedge mclk);
    ecc <= 3'h0;
    rchk(fcr_pkg::IDX_COMMAND_STATUS, exp);
  endtask

  function automatic logic permitted(input logic [7:0] c, input logic s, input logic x);
    if (c == 8'h00 || c == 8'h05 || c == 8'h0F || c > 8'h12) return 1'b0;
    if (c == 8'h08 || c == 8'h0B) return s;
    if (s && x) return c == 8'h01 || c == 8'h02;
    if (c == 8'h0E) return s;
    if (c == 8'h0C) return !s;
    return 1'b1;
  endfunction

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, sp, sec, rsel, eany, eunc} = 8'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    nvo = 8'hA5;
    gaddr = 18'h0_0000;
    ecc = 3'h0;
    dly = 3;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    xfer(1'b1, fcr_pkg::IDX_CFG, 8'hFF);
    xfer(1'b0, fcr_pkg::IDX_STAT, 8'h00);
    chk(rd[7], 1'b0);
    rchk(fcr_pkg::IDX_CFG, 8'h93);
    repeat (20) @(posedge mclk);
    rchk(fcr_pkg::IDX_STAT, 8'h80);
    rchk(fcr_pkg::IDX_PPROT, 8'hFF);
    rchk(fcr_pkg::IDX_DPROT, 8'h9F);
    foreach (rsv[i]) begin
      xfer(1'b1, rsv[i], 8'hFF);
      rchk(rsv[i], rsv[i] == fcr_pkg::IDX_OPT ? 8'hA5 : 8'h00);
    end
    xfer(1'b1, 5'h11, 8'hFF);
    chk(err, 1'b1);
    chk(rel, 1'b0);
    // Each mode uses its own program-once phrase so none is programmed twice.
    // A clean erase-all releases security, so it runs last in each mode and the
    // secured special mode comes before the unsecured one.
    for (int m = 0; m < 4; m++) begin
      sp <= m[1];
      sec <= m[1] ^ m[0];
      foreach (codes[i]) begin
        s0 = starts;
        e = permitted(codes[i], m[1], m[1] ^ m[0]);
        launch(codes[i], codes[i] == 8'h03 ? 3'h2 : (codes[i] == 8'h07 ? 3'h5 : 3'h0), m[7:0]);
        chk(rd[5], !e);
        chk(starts - s0, e ? (codes[i] == 8'h08 ? 2 : 1) : 0);
        xfer(1'b1, fcr_pkg::IDX_STAT, 8'h30);
      end
    end
    chk(rel, 1'b1);
    sp <= 1'b0;
    sec <= 1'b0;
    dly = 30;
    go(8'h01, 3'h0, 8'h00);
    xfer(1'b1, fcr_pkg::IDX_CFG, 8'h00);
    xfer(1'b0, fcr_pkg::IDX_STAT, 8'h00);
    chk(rd[7], 1'b0);
    idle();
    rchk(fcr_pkg::IDX_CFG, 8'h93);
    dly = 3;
    sp <= 1'b1;
    xfer(1'b1, fcr_pkg::IDX_PPROT, 8'h7F);
    s0 = starts;
    launch(8'h08, 3'h0, 8'h00);
    chk(rd[4], 1'b1);
    launch(8'h01, 3'h0, 8'h00);
    chk(starts - s0, 0);
    xfer(1'b1, fcr_pkg::IDX_STAT, 8'h30);
    rchk(fcr_pkg::IDX_STAT, 8'h80);
    xfer(1'b1, fcr_pkg::IDX_PPROT, 8'hFF);
    launch(8'h08, 3'h1, 8'h00);
    chk(rd[5], 1'b1);
    xfer(1'b1, fcr_pkg::IDX_STAT, 8'h30);
    launch(8'h07, 3'h5, 8'h08);
    chk(rd[5:4], 2'h2);
    xfer(1'b1, fcr_pkg::IDX_STAT, 8'h30);
    eany <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      eunc <= k[0];
      launch(8'h01, 3'h0, 8'h00);
      chk(rd[1:0], {1'b1, k[0]});
    end
    {eany, eunc} <= 2'h0;
    chk(cirq, 1'b1);
    xfer(1'b1, fcr_pkg::IDX_CFG, 8'h03);
    repeat (2) @(posedge mclk);
    chk(cirq, 1'b0);
    xfer(1'b1, fcr_pkg::IDX_FCFG, 8'h03);
    ecc_rd(3'h4, 8'h03);
    chk(firq, 1'b1);
    xfer(1'b1, fcr_pkg::IDX_COMMAND_STATUS, 8'h03);
    xfer(1'b1, fcr_pkg::IDX_CFG, 8'h10);
    ecc_rd(3'h6, 8'h00);
    ecc_rd(3'h5, 8'h02);
    xfer(1'b1, fcr_pkg::IDX_COMMAND_STATUS, 8'h03);
    xfer(1'b1, fcr_pkg::IDX_CFG, 8'h00);
    ecc_rd(3'h6, 8'h01);
    for (int k = 0; k < 6; k++) begin
      gaddr <= ga[k];
      rsel <= gx[k][3];
      repeat (2) @(posedge mclk);
      chk(reg_o, gx[k][2:0]);
    end
    end_sim();
  end
endmodule

bind fcr_top fcr_properties fcr_properties_i (.mclk, .rst_n, .ce, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .glb_addr, .resource_area_select, .region, .arr_req,
  .security_released);
